/* dv/guard_link_asserts.sv */
// concurrent checks on the serial link between host and guard device
`timescale 1ns/1ps
module guard_link_asserts
    import guard_pkg::*;
#(
    parameter int PROG_CYC = PROGRAM_TIME_CYC
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESETN,
    // link
    input wire logic chip_select,
    input wire logic serial_shift_clock,
    input wire logic serial_data_in,
    input wire logic serial_data_out,
    input wire logic serial_data_out_oe
);
    logic [5:0] sk_cnt;
    logic [5:0] next_sk_cnt;
    logic [31:0] since_drop;
    logic [31:0] next_since_drop;
    logic sk_q;
    logic cs_q;

    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);

    // shift pulses in the current frame, and cycles since select last dropped
    always_comb begin
        next_sk_cnt = sk_cnt;
        if (!chip_select) begin
            next_sk_cnt = 6'h00;
        end else if (serial_shift_clock && !sk_q && sk_cnt != 6'h3F) begin
            next_sk_cnt = sk_cnt + 6'h01;
        end
        next_since_drop = since_drop;
        if (!chip_select && cs_q) begin
            next_since_drop = 32'h0;
        end else if (since_drop != 32'hFFFFFFFF) begin
            next_since_drop = since_drop + 32'h1;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            sk_cnt <= 6'h00;
            since_drop <= 32'h0;
            sk_q <= 1'b0;
            cs_q <= 1'b0;
        end else begin
            sk_cnt <= next_sk_cnt;
            since_drop <= next_since_drop;
            sk_q <= serial_shift_clock;
            cs_q <= chip_select;
        end
    end

    property p_busy_first;
        $rose(serial_data_out_oe) |-> !serial_data_out;
    endproperty
    property p_ready_holds;
        serial_data_out_oe && serial_data_out |=> !serial_data_out_oe || serial_data_out;
    endproperty
    property p_released;
        !chip_select [*6] |-> !serial_data_out_oe;
    endproperty
    // ready must come from the device's own timer, a fixed time after the drop
    property p_self_timed;
        $rose(serial_data_out) && serial_data_out_oe |->
            since_drop >= PROG_CYC && since_drop <= PROG_CYC + 16;
    endproperty
    property p_drop_after_ready;
        $rose(serial_data_out) && serial_data_out_oe |-> ##[1:64] !chip_select;
    endproperty
    property p_no_shift_status;
        serial_data_out_oe |-> !$rose(serial_shift_clock);
    endproperty
    property p_start_bit;
        $rose(serial_shift_clock) && sk_cnt == 6'h00 |-> serial_data_in;
    endproperty
    property p_frame_len;
        $fell(chip_select) |-> sk_cnt == 6'h00 || sk_cnt == 6'h09 || sk_cnt == 6'h19;
    endproperty
    property p_din_steady;
        serial_shift_clock && $past(serial_shift_clock) |-> $stable(serial_data_in);
    endproperty

    a_busy_first: assert property (p_busy_first) else $error("status not busy first");
    a_ready_holds: assert property (p_ready_holds) else $error("ready lost");
    a_released: assert property (p_released) else $error("driven while deselected");
    a_self_timed: assert property (p_self_timed) else $error("program time off");
    a_drop_after_ready: assert property (p_drop_after_ready) else $error("no drop");
    a_no_shift_status: assert property (p_no_shift_status) else $error("shift in status");
    a_start_bit: assert property (p_start_bit) else $error("start bit low");
    a_frame_len: assert property (p_frame_len) else $error("bad frame length");
    a_din_steady: assert property (p_din_steady) else $error("data moved");

    c_status: cover property ($rose(serial_data_out_oe));
    c_ready: cover property ($rose(serial_data_out) && serial_data_out_oe);
    c_long: cover property ($fell(chip_select) && sk_cnt == 6'h19);
    c_short: cover property ($fell(chip_select) && sk_cnt == 6'h09);
endmodule : guard_link_asserts

/* dv/tb_eeprom_program_guard_status.sv */
// bench: host and device joined, plus a second device driven bit by bit
`timescale 1ns/1ps
module tb_eeprom_program_guard_status;
    import guard_pkg::*;
    localparam int PROG = 2000;
    localparam int WIN = 1000;
    localparam int LIMIT = 80000;
    localparam logic [1:0] T_OP [4] = '{OP_WRITE, OP_ERASE, OP_EXT, OP_EXT};
    localparam logic [5:0] T_ADDR [4] = '{6'h05, 6'h3F, {EXT_WRITE_ALL, 4'h0},
        {EXT_ERASE_ALL, 4'h0}};
    localparam logic [15:0] T_DATA [4] = '{16'hA5C3, 16'h1234, 16'h0F0F, 16'h5555};
    localparam logic [15:0] T_EXP [4] = '{16'hA5C3, ERASED_WORD, 16'h0F0F, ERASED_WORD};
    localparam logic [24:0] W25 = {1'b1, OP_WRITE, 6'h09, 16'hBEEF};
    localparam logic [24:0] EN9 = {16'h0000, 1'b1, OP_EXT, EXT_ENABLE, 4'h0};
    localparam logic [24:0] DIS9 = {16'h0000, 1'b1, OP_EXT, EXT_DISABLE, 4'h0};
    logic SYS_CLK = 1'b0;
    logic RESETN = 1'b0;
    logic rst2_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic [1:0] cmd_op = 2'h0;
    logic [ADDR_BITS-1:0] cmd_addr = 6'h00;
    logic [DATA_BITS-1:0] cmd_data = 16'h0000;
    logic cmd_ready, cmd_done, enabled, busy, c_valid, c_all, en2, busy2, cv2, got_all;
    logic [ADDR_BITS-1:0] c_addr, got_addr;
    logic [DATA_BITS-1:0] c_data, got_data;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    int n_commit, busy_cyc, en_seen, n_commit2, busy2_cyc;

    guard_link_if lk();
    guard_link_if lk2();
    guard_device #(.PROG_CYC(PROG), .WINDOW_CYC(WIN)) guard_device_i (.SYS_CLK(SYS_CLK),
        .RESETN(RESETN), .LINK(lk.dev), .PROGRAM_ENABLED(enabled), .BUSY(busy),
        .COMMIT_VALID(c_valid), .COMMIT_ADDR(c_addr), .COMMIT_DATA(c_data), .COMMIT_ALL(c_all));
    guard_host #(.PROG_CYC(PROG)) guard_host_i (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
        .LINK(lk.host), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op), .CMD_ADDR(cmd_addr),
        .CMD_DATA(cmd_data), .CMD_READY(cmd_ready), .CMD_DONE(cmd_done));
    // second device faces the bench, which breaks the host's rules on purpose
    guard_device #(.PROG_CYC(PROG), .WINDOW_CYC(WIN)) guard_device_i2 (.SYS_CLK(SYS_CLK),
        .RESETN(rst2_n), .LINK(lk2.dev), .PROGRAM_ENABLED(en2), .BUSY(busy2),
        .COMMIT_VALID(cv2), .COMMIT_ADDR(), .COMMIT_DATA(), .COMMIT_ALL());
    guard_link_asserts #(.PROG_CYC(PROG)) guard_link_asserts_i (.SYS_CLK(SYS_CLK),
        .RESETN(RESETN), .chip_select(lk.chip_select),
        .serial_shift_clock(lk.serial_shift_clock), .serial_data_in(lk.serial_data_in),
        .serial_data_out(lk.serial_data_out), .serial_data_out_oe(lk.serial_data_out_oe));

    always #5 SYS_CLK = ~SYS_CLK;

    initial begin
        lk2.chip_select = 1'b0;
        lk2.serial_shift_clock = 1'b0;
        lk2.serial_data_in = 1'b0;
    end

    // sampled mid-cycle so every flop has settled
    always @(negedge SYS_CLK) begin
        if (busy === 1'b1) busy_cyc++;
        if (busy2 === 1'b1) busy2_cyc++;
        if (enabled === 1'b1) en_seen = 1;
        if (cv2 === 1'b1) n_commit2++;
        if (c_valid === 1'b1) begin
            n_commit++;
            got_addr = c_addr;
            got_data = c_data;
            got_all = c_all;
        end
    end

    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            close_out();
        end
    end

    task automatic close_out();
        if (failures == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // valid is held until an edge with ready high has taken it
    task automatic run_cmd(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d);
        @(negedge SYS_CLK);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        while (cmd_ready !== 1'b1) @(negedge SYS_CLK);
        @(negedge SYS_CLK);
        cmd_valid = 1'b0;
        while (cmd_done !== 1'b1) @(negedge SYS_CLK);
        repeat (8) @(negedge SYS_CLK);
    endtask : run_cmd

    task automatic s_program();
        for (int i = 0; i < 4; i++) begin
            n_commit = 0;
            busy_cyc = 0;
            en_seen = 0;
            run_cmd(T_OP[i], T_ADDR[i], T_DATA[i]);
            chk(n_commit, 1);
            chk(busy_cyc >= PROG && busy_cyc <= PROG + 16, 1);
            chk(got_data, T_EXP[i]);
            chk(got_all, i >= 2);
            if (i < 2) chk(got_addr, T_ADDR[i]);
            chk(en_seen, 1);
            chk(enabled, 1'b0);
        end
    endtask : s_program

    task automatic s_read();
        n_commit = 0;
        busy_cyc = 0;
        run_cmd(OP_READ, 6'h05, 16'h0000);
        chk(busy_cyc, 0);
        chk(n_commit, 0);
    endtask : s_read

    // bench-made shift clock, not tied to the system clock's phase
    task automatic shift2(input logic [24:0] v, input int n);
        @(negedge SYS_CLK);
        lk2.chip_select = 1'b1;
        #125;
        for (int i = n - 1; i >= 0; i--) begin
            lk2.serial_data_in = v[i];
            #62.5 lk2.serial_shift_clock = 1'b1;
            #62.5 lk2.serial_shift_clock = 1'b0;
        end
        lk2.serial_data_in = ~lk2.serial_data_in;
        @(negedge SYS_CLK);
        lk2.chip_select = 1'b0;
        repeat (50) @(negedge SYS_CLK);
    endtask : shift2

    task automatic s_guard();
        busy2_cyc = 0;
        n_commit2 = 0;
        chk(en2, 1'b0);
        shift2(W25, 25);
        chk(busy2_cyc, 0);
        shift2(EN9, 9);
        chk(en2, 1'b1);
        shift2(W25 >> 5, 20);
        chk(busy2_cyc, 0);
        shift2(W25, 25);
        // reselect only after the status window has closed
        repeat (WIN + 100) @(negedge SYS_CLK);
        lk2.chip_select = 1'b1;
        repeat (20) @(negedge SYS_CLK);
        chk(lk2.serial_data_out_oe, 1'b0);
        lk2.chip_select = 1'b0;
        repeat (PROG) @(negedge SYS_CLK);
        chk(n_commit2, 1);
        chk(busy2_cyc >= PROG && busy2_cyc <= PROG + 16, 1);
        chk(en2, 1'b1);
        shift2(DIS9, 9);
        chk(en2, 1'b0);
        shift2(EN9, 9);
        rst2_n = 1'b0;
        repeat (3) @(negedge SYS_CLK);
        rst2_n = 1'b1;
        repeat (2) @(negedge SYS_CLK);
        chk(en2, 1'b0);
    endtask : s_guard

    initial begin
        repeat (3) @(posedge SYS_CLK);
        @(negedge SYS_CLK);
        RESETN = 1'b1;
        rst2_n = 1'b1;
        repeat (4) @(negedge SYS_CLK);
        chk(enabled, 1'b0);
        chk(cmd_ready, 1'b0);
        s_program();
        s_read();
        s_guard();
        close_out();
    end
endmodule : tb_eeprom_program_guard_status

/* rtl/guard_device.sv */
// device end: instruction shifter, program lock, self-timed programming and status
`timescale 1ns/1ps
module guard_device
    import guard_pkg::*;
#(
    parameter int PROG_CYC = PROGRAM_TIME_CYC,
    parameter int WINDOW_CYC = STATUS_WINDOW_CYC
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESETN,
    // link
    guard_link_if.dev LINK,
    // state seen by the user side
    output logic PROGRAM_ENABLED,
    output logic BUSY,
    output logic COMMIT_VALID,
    output logic [ADDR_BITS-1:0] COMMIT_ADDR,
    output logic [DATA_BITS-1:0] COMMIT_DATA,
    output logic COMMIT_ALL
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SHIFT = 3'b001,
        ST_WAIT_DESELECT = 3'b010,
        ST_PROGRAM = 3'b011,
        ST_DONE = 3'b100
    } dev_state_e;

    logic [1:0] cs_sync, sk_sync, di_sync;
    logic sk_prev, cs_prev;
    dev_state_e state, next_state;
    logic [4:0] bit_cnt, next_bit_cnt;
    logic [24:0] shift, next_shift;
    logic enabled, next_enabled;
    logic [31:0] timer, next_timer;
    logic status_ok, next_status_ok;
    logic do_q, next_do_q, oe_q, next_oe_q;
    logic cv, next_cv, call, next_call;
    logic [ADDR_BITS-1:0] caddr, next_caddr;
    logic [DATA_BITS-1:0] cdata, next_cdata;
    logic busy_q, next_busy;
    logic [1:0] op;
    logic [ADDR_BITS-1:0] adr;
    logic needs_data, is_prog, sk_rise, cs_fall, cs_rise;

    function automatic logic [4:0] bits_needed(input logic [1:0] opc, input logic [1:0] ext);
        if (opc == OP_WRITE || (opc == OP_EXT && ext == EXT_WRITE_ALL)) begin
            bits_needed = CMD_BITS_W;
        end else begin
            bits_needed = 5'(INSTR_BITS);
        end
    endfunction : bits_needed

    // pins are asynchronous to SYS_CLK; two stages before anything reads them
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            cs_sync <= 2'h0;
            sk_sync <= 2'h0;
            di_sync <= 2'h0;
            sk_prev <= 1'b0;
            cs_prev <= 1'b0;
        end else begin
            cs_sync <= {cs_sync[0], LINK.chip_select};
            sk_sync <= {sk_sync[0], LINK.serial_shift_clock};
            di_sync <= {di_sync[0], LINK.serial_data_in};
            sk_prev <= sk_sync[1];
            cs_prev <= cs_sync[1];
        end
    end

    assign sk_rise = sk_sync[1] & ~sk_prev;
    assign cs_fall = ~cs_sync[1] & cs_prev;
    assign cs_rise = cs_sync[1] & ~cs_prev;
    // shift holds start bit at the top of the first nine bits
    assign op = (bit_cnt >= 5'(INSTR_BITS)) ? shift[bit_cnt-5'd2 -: 2] : 2'h0;
    assign adr = (bit_cnt >= 5'(INSTR_BITS)) ? shift[bit_cnt-5'd4 -: 6] : 6'h0;
    assign needs_data = (op == OP_WRITE) || (op == OP_EXT && adr[5:4] == EXT_WRITE_ALL);
    assign is_prog = (op != OP_READ) && !(op == OP_EXT && adr[5] == adr[4]);

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        next_enabled = enabled;
        next_timer = timer;
        next_status_ok = status_ok;
        next_do_q = do_q;
        next_oe_q = 1'b0;
        next_cv = 1'b0;
        next_call = call;
        next_caddr = caddr;
        next_cdata = cdata;
        case (state)
            ST_IDLE: begin
                next_bit_cnt = 5'h0;
                // wait for the start bit, a one on data in at a shift edge
                if (cs_sync[1] && sk_rise && di_sync[1]) begin
                    next_shift = 25'h1;
                    next_bit_cnt = 5'h1;
                    next_state = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (!cs_sync[1]) begin
                    // an instruction cut short by deselect does nothing
                    next_state = ST_IDLE;
                end else if (sk_rise) begin
                    next_shift = {shift[23:0], di_sync[1]};
                    next_bit_cnt = bit_cnt + 5'h1;
                    // with eight bits in, opcode sits at [6:5] and the extended code at [4:3]
                    if (bit_cnt == 5'(INSTR_BITS - 1)
                            && bits_needed(shift[6:5], shift[4:3]) == 5'(INSTR_BITS)) begin
                        next_state = ST_WAIT_DESELECT;
                    end else if (bit_cnt == CMD_BITS_W - 5'h1) begin
                        next_state = ST_WAIT_DESELECT;
                    end
                end
            end
            ST_WAIT_DESELECT: begin
                if (cs_fall) begin
                    next_state = ST_IDLE;
                    if (op == OP_EXT && adr[5:4] == EXT_ENABLE) begin
                        next_enabled = 1'b1;
                    end else if (op == OP_EXT && adr[5:4] == EXT_DISABLE) begin
                        next_enabled = 1'b0;
                    end else if (is_prog && enabled) begin
                        // timer starts on deselect after the last bit
                        next_state = ST_PROGRAM;
                        next_timer = 32'h0;
                        next_status_ok = 1'b1;
                        next_call = (op == OP_EXT);
                        next_caddr = adr;
                        next_cdata = needs_data ? shift[DATA_BITS-1:0] : ERASED_WORD;
                    end
                    // locked: erase and write are dropped unseen
                end
            end
            ST_PROGRAM: begin
                next_timer = timer + 32'h1;
                if (timer >= 32'(WINDOW_CYC) && !cs_sync[1]) begin
                    next_status_ok = 1'b0;
                end
                if (cs_sync[1] && status_ok) begin
                    next_oe_q = 1'b1;
                    next_do_q = 1'b0;
                end
                if (timer == 32'(PROG_CYC - 1)) begin
                    next_cv = 1'b1;
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                if (cs_sync[1] && status_ok) begin
                    next_oe_q = 1'b1;
                    next_do_q = 1'b1;
                end else begin
                    next_state = ST_IDLE;
                    next_status_ok = 1'b0;
                end
                // a fresh select after ready is a new instruction, not status
                if (cs_rise) begin
                    next_state = ST_IDLE;
                    next_oe_q = 1'b0;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        next_busy = (next_state == ST_PROGRAM);
    end

    // reset sets the lock, standing in for power-up; the disable instruction sets it too
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state <= ST_IDLE;
            bit_cnt <= 5'h0;
            shift <= 25'h0;
            enabled <= 1'b0;
            timer <= 32'h0;
            status_ok <= 1'b0;
            do_q <= 1'b0;
            oe_q <= 1'b0;
            cv <= 1'b0;
            call <= 1'b0;
            caddr <= '0;
            cdata <= '0;
            busy_q <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            enabled <= next_enabled;
            timer <= next_timer;
            status_ok <= next_status_ok;
            do_q <= next_do_q;
            oe_q <= next_oe_q;
            cv <= next_cv;
            call <= next_call;
            caddr <= next_caddr;
            cdata <= next_cdata;
            busy_q <= next_busy;
        end
    end

    assign LINK.serial_data_out = do_q;
    assign LINK.serial_data_out_oe = oe_q;
    assign PROGRAM_ENABLED = enabled;
    assign BUSY = busy_q;
    assign COMMIT_VALID = cv;
    assign COMMIT_ADDR = caddr;
    assign COMMIT_DATA = cdata;
    assign COMMIT_ALL = call;
endmodule : guard_device

/* rtl/guard_host.sv */
// host end: shifts one command, brackets programming, watches status
`timescale 1ns/1ps
module guard_host
    import guard_pkg::*;
#(
    parameter int PROG_CYC = PROGRAM_TIME_CYC
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESETN,
    // link
    guard_link_if.host LINK,
    // command port
    input wire logic CMD_VALID,
    input wire logic [1:0] CMD_OP,
    input wire logic [ADDR_BITS-1:0] CMD_ADDR,
    input wire logic [DATA_BITS-1:0] CMD_DATA,
    output logic CMD_READY,
    output logic CMD_DONE
);
    typedef enum logic [2:0] {
        H_INIT = 3'b000,
        H_IDLE = 3'b001,
        H_SEND = 3'b010,
        H_GAP = 3'b011,
        H_STATUS = 3'b100,
        H_WAIT = 3'b101
    } host_state_e;

    host_state_e state, next_state;
    logic [1:0] seq, next_seq;
    logic [24:0] word, next_word;
    logic [4:0] left, next_left;
    logic [7:0] div, next_div;
    logic sk, next_sk, cs, next_cs, di, next_di;
    logic [31:0] wait_cnt, next_wait_cnt;
    logic [1:0] do_sync;
    logic [1:0] oe_sync;
    logic rdy, next_rdy, done, next_done;
    logic [1:0] op_q, next_op_q;
    logic [ADDR_BITS-1:0] a_q, next_a_q;
    logic [DATA_BITS-1:0] d_q, next_d_q;

    function automatic logic [24:0] frame(input logic [1:0] o, input logic [5:0] a,
        input logic [15:0] d);
        frame = {1'b1, o, a, d};
    endfunction : frame

    function automatic logic [4:0] length(input logic [1:0] o, input logic [5:0] a);
        if (o == OP_WRITE || (o == OP_EXT && a[5:4] == EXT_WRITE_ALL)) begin
            length = CMD_BITS_W;
        end else begin
            length = 5'(INSTR_BITS);
        end
    endfunction : length

    function automatic logic programs(input logic [1:0] o, input logic [5:0] a);
        programs = (o != OP_READ) && !(o == OP_EXT && a[5] == a[4]);
    endfunction : programs

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            do_sync <= 2'h0;
            oe_sync <= 2'h0;
        end else begin
            do_sync <= {do_sync[0], LINK.serial_data_out};
            oe_sync <= {oe_sync[0], LINK.serial_data_out_oe};
        end
    end

    always_comb begin
        next_state = state;
        next_seq = seq;
        next_word = word;
        next_left = left;
        next_div = div;
        next_sk = sk;
        next_cs = cs;
        next_di = di;
        next_wait_cnt = wait_cnt;
        next_rdy = 1'b0;
        next_done = 1'b0;
        next_op_q = op_q;
        next_a_q = a_q;
        next_d_q = d_q;
        case (state)
            H_INIT: begin
                // disable first thing after power-up
                next_word = frame(OP_EXT, {EXT_DISABLE, 4'h0}, 16'h0);
                next_left = 5'(INSTR_BITS);
                next_seq = 2'h3;
                next_cs = 1'b1;
                // start bit stands on data in before the first shift edge
                next_di = 1'b1;
                next_state = H_SEND;
            end
            H_IDLE: begin
                next_rdy = 1'b1;
                if (CMD_VALID && rdy) begin
                    next_rdy = 1'b0;
                    next_op_q = CMD_OP;
                    next_a_q = CMD_ADDR;
                    next_d_q = CMD_DATA;
                    next_cs = 1'b1;
                    next_di = 1'b1;
                    next_state = H_SEND;
                    if (programs(CMD_OP, CMD_ADDR)) begin
                        // enable just before programming
                        next_word = frame(OP_EXT, {EXT_ENABLE, 4'h0}, 16'h0);
                        next_left = 5'(INSTR_BITS);
                        next_seq = 2'h0;
                    end else begin
                        next_word = frame(CMD_OP, CMD_ADDR, CMD_DATA);
                        next_left = length(CMD_OP, CMD_ADDR);
                        next_seq = 2'h2;
                    end
                end
            end
            H_SEND: begin
                next_div = div + 8'h1;
                if (div == 8'(SHIFT_HALF_CYC - 1)) begin
                    next_div = 8'h0;
                    next_sk = ~sk;
                    // data moves on the falling edge so it is settled at the next rise
                    if (sk) begin
                        next_di = word[23];
                        next_word = {word[23:0], 1'b0};
                        next_left = left - 5'h1;
                        if (left == 5'h1) begin
                            next_cs = 1'b0;
                            next_wait_cnt = 32'h0;
                            next_state = (seq == 2'h1) ? H_STATUS : H_GAP;
                        end
                    end
                end
            end
            H_GAP: begin
                next_wait_cnt = wait_cnt + 32'h1;
                if (wait_cnt == 32'(SHIFT_HALF_CYC)) begin
                    next_cs = 1'b1;
                    next_di = 1'b1;
                    next_state = H_SEND;
                    if (seq == 2'h0) begin
                        next_word = frame(op_q, a_q, d_q);
                        next_left = length(op_q, a_q);
                        next_seq = 2'h1;
                    end else if (seq == 2'h1) begin
                        // disable right after programming
                        next_word = frame(OP_EXT, {EXT_DISABLE, 4'h0}, 16'h0);
                        next_left = 5'(INSTR_BITS);
                        next_seq = 2'h2;
                    end else begin
                        next_cs = 1'b0;
                        next_done = (seq == 2'h2);
                        next_state = H_IDLE;
                    end
                end
            end
            H_STATUS: begin
                // reselect well inside the status window
                next_wait_cnt = wait_cnt + 32'h1;
                if (wait_cnt == 32'(SHIFT_HALF_CYC)) begin
                    next_cs = 1'b1;
                end
                // data out keeps its last level when released; only trust it while driven
                if (cs && wait_cnt > 32'(SHIFT_HALF_CYC + 4) && do_sync[1] && oe_sync[1]) begin
                    next_cs = 1'b0;
                    next_wait_cnt = 32'h0;
                    next_state = H_GAP;
                end else if (wait_cnt == 32'(PROG_CYC)) begin
                    // no ready seen: full program time already elapsed
                    next_cs = 1'b0;
                    next_wait_cnt = 32'h0;
                    next_state = H_GAP;
                end
            end
            default: next_state = H_IDLE;
        endcase
        if (state == H_GAP && seq == 2'h3) begin
            next_seq = 2'h3;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state <= H_INIT;
            seq <= 2'h0;
            word <= 25'h0;
            left <= 5'h0;
            div <= 8'h0;
            sk <= 1'b0;
            cs <= 1'b0;
            di <= 1'b0;
            wait_cnt <= 32'h0;
            rdy <= 1'b0;
            done <= 1'b0;
            op_q <= 2'h0;
            a_q <= '0;
            d_q <= '0;
        end else begin
            state <= next_state;
            seq <= next_seq;
            word <= next_word;
            left <= next_left;
            div <= next_div;
            sk <= next_sk;
            cs <= next_cs;
            di <= next_di;
            wait_cnt <= next_wait_cnt;
            rdy <= next_rdy;
            done <= next_done;
            op_q <= next_op_q;
            a_q <= next_a_q;
            d_q <= next_d_q;
        end
    end

    assign LINK.chip_select = cs;
    assign LINK.serial_shift_clock = sk;
    assign LINK.serial_data_in = di;
    assign CMD_READY = rdy;
    assign CMD_DONE = done;
endmodule : guard_host

/* rtl/guard_link_if.sv */
// serial link between host and guard device
`timescale 1ns/1ps
interface guard_link_if;
    logic chip_select;
    logic serial_shift_clock;
    logic serial_data_in;
    logic serial_data_out;
    logic serial_data_out_oe;
    modport dev (input chip_select, input serial_shift_clock, input serial_data_in,
        output serial_data_out, output serial_data_out_oe);
    modport host (output chip_select, output serial_shift_clock, output serial_data_in,
        input serial_data_out, input serial_data_out_oe);
endinterface : guard_link_if

/* rtl/guard_pkg.sv */
// constants shared by the serial guard device and its host controller
package guard_pkg;
    localparam int CLK_MHZ = 100;
    localparam int INSTR_BITS = 9;
    localparam int OPCODE_BITS = 2;
    localparam int ADDR_BITS = 6;
    localparam int DATA_BITS = 16;
    localparam int STATUS_WINDOW_US = 1000;
    localparam int STATUS_WINDOW_CYC = STATUS_WINDOW_US * CLK_MHZ;
    localparam int PROGRAM_TIME_US = 10000;
    localparam int PROGRAM_TIME_CYC = PROGRAM_TIME_US * CLK_MHZ;
    localparam int SHIFT_HALF_CYC = 40;
    localparam logic [1:0] OP_EXT = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] EXT_DISABLE = 2'h0;
    localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
    localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
    localparam logic [1:0] EXT_ENABLE = 2'h3;
    localparam logic [DATA_BITS-1:0] ERASED_WORD = 16'hFFFF;
    localparam logic [4:0] CMD_BITS_W = 5'h19;
endpackage : guard_pkg
